// file: rtl/cgo_pkg.sv
// Purpose: constants and types for the channel gain/offset register bank
// Assumes: AHB-Lite slave, 32-bit data, printed offsets are register indices
// Notes: byte address is four times the register index
// Functional notes
// - each channel holds its own 8-bit offset code, reset to 0x80
// - writing the offset broadcast location loads all three offset codes
// - red gain low register bit 0 is the red gain code LSB, reset 0
// - green gain low register bit 0 is the green gain code LSB
// - blue gain low register bit 0 is the blue gain code LSB
// - writing the gain low broadcast location copies bit 0 to all three channels
// - gain high registers supply gain code bits 8:1, reset 0x0C
// - writing the gain high broadcast location loads all three gain high registers
package cgo_pkg;
   localparam logic [5:0] CGO_IDX_RED_OFS = 6'h20;
   localparam logic [5:0] CGO_IDX_GRN_OFS = 6'h21;
   localparam logic [5:0] CGO_IDX_BLU_OFS = 6'h22;
   localparam logic [5:0] CGO_IDX_ALL_OFS = 6'h23;
   localparam logic [5:0] CGO_IDX_RED_GLO = 6'h24;
   localparam logic [5:0] CGO_IDX_GRN_GLO = 6'h25;
   localparam logic [5:0] CGO_IDX_BLU_GLO = 6'h26;
   localparam logic [5:0] CGO_IDX_ALL_GLO = 6'h27;
   localparam logic [5:0] CGO_IDX_RED_GHI = 6'h28;
   localparam logic [5:0] CGO_IDX_GRN_GHI = 6'h29;
   localparam logic [5:0] CGO_IDX_BLU_GHI = 6'h2A;
   localparam logic [5:0] CGO_IDX_ALL_GHI = 6'h2B;
   localparam logic [7:0] CGO_OFS_RESET = 8'h80;
   localparam logic [7:0] CGO_GHI_RESET = 8'h0C;
   localparam logic CGO_GLO_RESET = 1'b0;
   localparam int CGO_GAIN_LSB_POS = 0;
   localparam int CGO_CH_RED = 0;
   localparam int CGO_CH_GRN = 1;
   localparam int CGO_CH_BLU = 2;
   localparam logic [1:0] CGO_HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] CGO_HTRANS_SEQ = 2'b11;

   typedef struct packed
   {
      logic [8:0] red;
      logic [8:0] green;
      logic [8:0] blue;
   } cgo_gain_s;

   typedef struct packed
   {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } cgo_offset_s;
endpackage

// file: rtl/cgo_regs.sv
// Purpose: AHB-Lite register bank for per-channel offset and gain codes
// Assumes: single clock, zero wait states, response always OKAY
// Notes: broadcast locations are write-only and read as zero
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
module cgo_regs
   import cgo_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output cgo_offset_s offset_code,
   output cgo_gain_s gain_code
);
   logic [7:0] ofs_q [3];
   logic [7:0] ghi_q [3];
   logic glo_q [3];
   logic wr_pend_q;
   logic [5:0] wr_idx_q;
   logic [31:0] rdata_d;
   logic [5:0] ap_idx;
   logic ap_valid;

   // index of a word address; bits above the map decode as unmapped
   function automatic logic [5:0] word_idx(input logic [31:0] a);
      word_idx = (a[31:8] == 24'h00_0000) ? a[7:2] : 6'h00;
   endfunction

   function automatic logic [31:0] read_mux(input logic [5:0] idx);
      read_mux = 32'h0000_0000;
      case (idx)
         CGO_IDX_RED_OFS: read_mux = {24'h00_0000, ofs_q[CGO_CH_RED]};
         CGO_IDX_GRN_OFS: read_mux = {24'h00_0000, ofs_q[CGO_CH_GRN]};
         CGO_IDX_BLU_OFS: read_mux = {24'h00_0000, ofs_q[CGO_CH_BLU]};
         CGO_IDX_RED_GLO: read_mux = {31'h0000_0000, glo_q[CGO_CH_RED]};
         CGO_IDX_GRN_GLO: read_mux = {31'h0000_0000, glo_q[CGO_CH_GRN]};
         CGO_IDX_BLU_GLO: read_mux = {31'h0000_0000, glo_q[CGO_CH_BLU]};
         CGO_IDX_RED_GHI: read_mux = {24'h00_0000, ghi_q[CGO_CH_RED]};
         CGO_IDX_GRN_GHI: read_mux = {24'h00_0000, ghi_q[CGO_CH_GRN]};
         CGO_IDX_BLU_GHI: read_mux = {24'h00_0000, ghi_q[CGO_CH_BLU]};
         default: read_mux = 32'h0000_0000;
      endcase
   endfunction

   assign ap_valid = hsel && hready && (htrans == CGO_HTRANS_NONSEQ || htrans == CGO_HTRANS_SEQ);
   assign ap_idx = word_idx(haddr);

   // write data arrives a cycle after the address, so the index is held
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 6'h00;
      end
      else
      begin
         wr_pend_q <= ap_valid && hwrite;
         wr_idx_q <= ap_idx;
      end
   end

   // offset codes, direct and broadcast
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 3; i++)
         begin
            ofs_q[i] <= CGO_OFS_RESET;
         end
      end
      else if (wr_pend_q)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (wr_idx_q == CGO_IDX_ALL_OFS || wr_idx_q == CGO_IDX_RED_OFS + 6'(i))
            begin
               ofs_q[i] <= hwdata[7:0];
            end
         end
      end
   end

   // gain low bits; bits 7:1 are not stored
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 3; i++)
         begin
            glo_q[i] <= CGO_GLO_RESET;
         end
      end
      else if (wr_pend_q)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (wr_idx_q == CGO_IDX_ALL_GLO || wr_idx_q == CGO_IDX_RED_GLO + 6'(i))
            begin
               glo_q[i] <= hwdata[CGO_GAIN_LSB_POS];
            end
         end
      end
   end

   // gain high bytes
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 3; i++)
         begin
            ghi_q[i] <= CGO_GHI_RESET;
         end
      end
      else if (wr_pend_q)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (wr_idx_q == CGO_IDX_ALL_GHI || wr_idx_q == CGO_IDX_RED_GHI + 6'(i))
            begin
               ghi_q[i] <= hwdata[7:0];
            end
         end
      end
   end

   // codes are registered so analogue side sees clean flop outputs
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         offset_code <= '{CGO_OFS_RESET, CGO_OFS_RESET, CGO_OFS_RESET};
         gain_code <= '{{CGO_GHI_RESET, CGO_GLO_RESET}, {CGO_GHI_RESET, CGO_GLO_RESET},
                        {CGO_GHI_RESET, CGO_GLO_RESET}};
      end
      else
      begin
         offset_code <= '{ofs_q[CGO_CH_RED], ofs_q[CGO_CH_GRN], ofs_q[CGO_CH_BLU]};
         gain_code.red <= {ghi_q[CGO_CH_RED], glo_q[CGO_CH_RED]};
         gain_code.green <= {ghi_q[CGO_CH_GRN], glo_q[CGO_CH_GRN]};
         gain_code.blue <= {ghi_q[CGO_CH_BLU], glo_q[CGO_CH_BLU]};
      end
   end

   // read data captured at the address phase, valid in the data phase
   always_comb
   begin
      rdata_d = hrdata;
      if (ap_valid && !hwrite)
      begin
         rdata_d = read_mux(ap_idx);
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         hrdata <= rdata_d;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // checks: reset values, seen on the first edge after release
   a_ofs_reset_val: assert property (@(posedge ref_clk)
      $fell(rst)
      |-> offset_code == {3{CGO_OFS_RESET}})
      else $error("offset codes not at midpoint after reset");

   a_msb_reset_val: assert property (@(posedge ref_clk)
      $fell(rst)
      |-> gain_code.red[8:1] == CGO_GHI_RESET && gain_code.green[8:1] == CGO_GHI_RESET &&
         gain_code.blue[8:1] == CGO_GHI_RESET)
      else $error("gain msb reset wrong");

   a_glo_reset_val: assert property (@(posedge ref_clk)
      $fell(rst)
      |-> {gain_code.red[0], gain_code.green[0], gain_code.blue[0]} == {3{CGO_GLO_RESET}})
      else $error("gain lsb reset wrong");

   // bus side: zero wait, okay response, read data stands
   a_rdy_in_reset: assert property (@(posedge ref_clk)
      rst
      |-> hreadyout == 1'b0)
      else $error("ready high during reset");

   a_rdy_after_rst: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst)
      |-> hreadyout == 1'b1)
      else $error("ready low outside reset");

   a_resp_okay: assert property (@(posedge ref_clk)
      1'b1
      |-> hresp == 1'b0)
      else $error("response not okay");

   a_rd_hold_data: assert property (@(posedge ref_clk) disable iff (rst)
      !(ap_valid && !hwrite)
      |=> $stable(hrdata))
      else $error("read data moved without a read");

   a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
      ap_valid && !hwrite && (ap_idx < CGO_IDX_RED_OFS || ap_idx > CGO_IDX_ALL_GHI)
      |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   a_rd_bcast_zero: assert property (@(posedge ref_clk) disable iff (rst)
      ap_valid && !hwrite && (ap_idx == CGO_IDX_ALL_OFS || ap_idx == CGO_IDX_ALL_GLO ||
         ap_idx == CGO_IDX_ALL_GHI)
      |=> hrdata == 32'h0000_0000)
      else $error("broadcast location read not zero");

   a_rd_ofs_upper: assert property (@(posedge ref_clk) disable iff (rst)
      ap_valid && !hwrite && ap_idx >= CGO_IDX_RED_OFS && ap_idx <= CGO_IDX_BLU_OFS
      |=> hrdata[31:8] == 24'h00_0000)
      else $error("offset read upper bits not zero");

   a_lsb_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
      ap_valid && !hwrite && ap_idx >= CGO_IDX_RED_GLO && ap_idx <= CGO_IDX_BLU_GLO
      |=> hrdata[31:1] == 31'h0000_0000)
      else $error("reserved gain bits not zero");

   // direct writes reach the outputs two edges after the data phase edge
   a_red_ofs_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_RED_OFS
      |=> ##1 offset_code.red == $past(hwdata[7:0], 2))
      else $error("red offset write missed");

   a_grn_ofs_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_GRN_OFS
      |=> ##1 offset_code.green == $past(hwdata[7:0], 2))
      else $error("green offset write missed");

   a_blu_ofs_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_BLU_OFS
      |=> ##1 offset_code.blue == $past(hwdata[7:0], 2))
      else $error("blue offset write missed");

   a_red_lsb_path: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_RED_GLO
      |=> ##1 gain_code.red[0] == $past(hwdata[0], 2))
      else $error("red gain lsb wrong");

   a_grn_lsb_path: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_GRN_GLO
      |=> ##1 gain_code.green[0] == $past(hwdata[0], 2))
      else $error("green gain lsb wrong");

   a_blu_lsb_path: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_BLU_GLO
      |=> ##1 gain_code.blue[0] == $past(hwdata[0], 2))
      else $error("blue gain lsb wrong");

   a_red_msb_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_RED_GHI
      |=> ##1 gain_code.red[8:1] == $past(hwdata[7:0], 2))
      else $error("red gain msb write missed");

   a_grn_msb_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_GRN_GHI
      |=> ##1 gain_code.green[8:1] == $past(hwdata[7:0], 2))
      else $error("green gain msb write missed");

   a_blu_msb_write: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_BLU_GHI
      |=> ##1 gain_code.blue[8:1] == $past(hwdata[7:0], 2))
      else $error("blue gain msb write missed");

   // broadcast writes, at the outputs and in the registers
   a_ofs_bcast_all: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_ALL_OFS
      |=> ##1 offset_code == {3{$past(hwdata[7:0], 2)}})
      else $error("offset broadcast missed");

   a_lsb_bcast_all: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_ALL_GLO
      |=> ##1 {gain_code.red[0], gain_code.green[0], gain_code.blue[0]} == {3{$past(hwdata[0], 2)}})
      else $error("gain lsb broadcast missed");

   a_msb_bcast_all: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_ALL_GHI
      |=> ##1 {gain_code.red[8:1], gain_code.green[8:1], gain_code.blue[8:1]} ==
         {3{$past(hwdata[7:0], 2)}})
      else $error("gain msb broadcast missed");

   a_ofs_reg_bcast: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_ALL_OFS
      |=> ofs_q[0] == $past(hwdata[7:0]) && ofs_q[1] == $past(hwdata[7:0]) &&
         ofs_q[2] == $past(hwdata[7:0]))
      else $error("offset registers not all loaded");

   a_glo_reg_bcast: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_ALL_GLO
      |=> glo_q[0] == $past(hwdata[0]) && glo_q[1] == $past(hwdata[0]) &&
         glo_q[2] == $past(hwdata[0]))
      else $error("gain lsb registers not all loaded");

   a_ghi_reg_bcast: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && wr_idx_q == CGO_IDX_ALL_GHI
      |=> ghi_q[0] == $past(hwdata[7:0]) && ghi_q[1] == $past(hwdata[7:0]) &&
         ghi_q[2] == $past(hwdata[7:0]))
      else $error("gain msb registers not all loaded");

   // no write, no change; unmapped writes leave the offset and gain high registers unchanged
   a_ofs_hold_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_pend_q
      |=> $stable(ofs_q[0]) && $stable(ofs_q[1]) && $stable(ofs_q[2]))
      else $error("offset register moved without a write");

   a_glo_hold_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_pend_q
      |=> $stable(glo_q[0]) && $stable(glo_q[1]) && $stable(glo_q[2]))
      else $error("gain lsb moved without a write");

   a_ghi_hold_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !wr_pend_q
      |=> $stable(ghi_q[0]) && $stable(ghi_q[1]) && $stable(ghi_q[2]))
      else $error("gain msb moved without a write");

   a_unmap_wr_none: assert property (@(posedge ref_clk) disable iff (rst)
      wr_pend_q && (wr_idx_q < CGO_IDX_RED_OFS || wr_idx_q > CGO_IDX_ALL_GHI)
      |=> $stable(ofs_q[0]) && $stable(ofs_q[1]) && $stable(ofs_q[2]) &&
         $stable(ghi_q[0]) && $stable(ghi_q[1]) && $stable(ghi_q[2]))
      else $error("unmapped write changed a register");

   // outputs follow the registers one edge late
   a_ofs_out_track: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst)
      |-> offset_code.red == $past(ofs_q[0]) && offset_code.green == $past(ofs_q[1]) &&
         offset_code.blue == $past(ofs_q[2]))
      else $error("offset outputs do not follow registers");

   a_gain_out_track: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst)
      |-> gain_code.red == {$past(ghi_q[0]), $past(glo_q[0])} &&
         gain_code.green == {$past(ghi_q[1]), $past(glo_q[1])} &&
         gain_code.blue == {$past(ghi_q[2]), $past(glo_q[2])})
      else $error("gain outputs do not follow registers");
endmodule

// file: testbench/cgo_host_model.sv
// Purpose: host controller model, the AHB-Lite master of the register bank
// Assumes: single whole-word transfers, one slave, hready from the slave
// Notes: released lines flip to the inverse so stale values never pass
`timescale 1ns/10ps
module cgo_host_model
   import cgo_pkg::*;
(
   input wire logic ref_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // one transfer; the task waits an edge first, so an idle cycle precedes each transfer
   task automatic xfer(input logic we, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, idx, 2'b00};
      htrans <= CGO_HTRANS_NONSEQ;
      hwrite <= we;
      hsize <= 3'h2;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~haddr;
      hwdata <= wd;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~wd;
   endtask
endmodule

// file: testbench/channel_gain_offset_regs_tb.sv
// Purpose: self-checking bench for the channel gain/offset register bank
// Assumes: zero-wait slave, outputs settle two edges after a write
// Notes: reset values first, then table rows, final outputs and a mid-run reset
`timescale 1ns/10ps
module channel_gain_offset_regs_tb
   import cgo_pkg::*;
();
   typedef struct packed {logic we; logic [5:0] idx; logic [7:0] d;} cgo_row_s;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   cgo_offset_s offset_code;
   cgo_gain_s gain_code;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   // reads carry the expected byte in d; gain low writes keep bits 7:1 zero
   cgo_row_s rows [0:21] = '{
      '{1'b0, CGO_IDX_RED_OFS, 8'h80}, '{1'b0, CGO_IDX_BLU_OFS, 8'h80},
      '{1'b0, CGO_IDX_RED_GLO, 8'h00}, '{1'b0, CGO_IDX_GRN_GHI, 8'h0C},
      '{1'b1, CGO_IDX_ALL_OFS, 8'hA5}, '{1'b0, CGO_IDX_GRN_OFS, 8'hA5},
      '{1'b1, CGO_IDX_GRN_OFS, 8'h3C}, '{1'b0, CGO_IDX_GRN_OFS, 8'h3C},
      '{1'b0, CGO_IDX_RED_OFS, 8'hA5}, '{1'b0, CGO_IDX_ALL_OFS, 8'h00},
      '{1'b1, CGO_IDX_ALL_GLO, 8'h01}, '{1'b0, CGO_IDX_BLU_GLO, 8'h01},
      '{1'b1, CGO_IDX_GRN_GLO, 8'h00}, '{1'b0, CGO_IDX_GRN_GLO, 8'h00},
      '{1'b0, CGO_IDX_RED_GLO, 8'h01}, '{1'b1, CGO_IDX_BLU_GLO, 8'h00},
      '{1'b0, CGO_IDX_BLU_GLO, 8'h00}, '{1'b1, CGO_IDX_ALL_GHI, 8'h5A},
      '{1'b0, CGO_IDX_BLU_GHI, 8'h5A}, '{1'b0, CGO_IDX_ALL_GLO, 8'h00},
      '{1'b1, 6'h3F, 8'h77}, '{1'b0, 6'h3F, 8'h00}};

   cgo_host_model host_u (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   cgo_regs dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .offset_code(offset_code), .gain_code(gain_code));

   initial
   begin
      forever #20 ref_clk = ~ref_clk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // whole run needs well under 300 cycles
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         give_verdict;
      end
   end

   task chk_reset;
      chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
      chk({8'h00, offset_code}, {8'h00, {3{CGO_OFS_RESET}}});
      chk({5'h00, gain_code}, {5'h00, {3{9'h018}}});
   endtask

   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk_reset;
      foreach (rows[i])
      begin
         host_u.xfer(rows[i].we, rows[i].idx, {24'h00_0000, rows[i].d}, rd);
         if (!rows[i].we)
            chk(rd, {24'h00_0000, rows[i].d});
         chk({31'h0000_0000, hresp}, 32'h0000_0000);
      end
      repeat (2) @(posedge ref_clk);
      chk({8'h00, offset_code}, {8'h00, 8'hA5, 8'h3C, 8'hA5});
      chk({5'h00, gain_code}, {5'h00, 9'h0B5, 9'h0B4, 9'h0B4});
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk_reset;
      give_verdict;
   end
endmodule
